// ---- rtl/bcp_pkg.sv ----
// package: constants, types and carriers for the brush/clip/pick write stage
package bcp_pkg;
    // geometry of this device
    localparam int BCP_CW = 12;
    localparam int BCP_NP = 4;
    localparam logic [11:0] BCP_MAX_X = 12'hFFF;
    localparam logic [11:0] BCP_MAX_Y = 12'hFFF;
    // register byte offsets
    localparam logic [7:0] BCP_A_CTRL = 8'h00;
    localparam logic [7:0] BCP_A_PLANES = 8'h04;
    localparam logic [7:0] BCP_A_BRUSH = 8'h08;
    localparam logic [7:0] BCP_A_BSIZE = 8'h0C;
    localparam logic [7:0] BCP_A_OFFS = 8'h10;
    localparam logic [7:0] BCP_A_CLIP_LO = 8'h14;
    localparam logic [7:0] BCP_A_CLIP_HI = 8'h18;
    localparam logic [7:0] BCP_A_PICK_LO = 8'h1C;
    localparam logic [7:0] BCP_A_PICK_HI = 8'h20;
    localparam logic [7:0] BCP_A_STATUS = 8'h24;
    // control register fields
    localparam int BCP_C_BRUSH = 0;
    localparam int BCP_C_CLIP = 1;
    localparam int BCP_C_PICK = 2;
    localparam int BCP_C_PSRC = 3;
    localparam int BCP_C_INV = 4;
    localparam int BCP_C_QUAL = 5;
    localparam int BCP_C_ROP = 6;
    // plane register fields
    localparam int BCP_P_ACT = 0;
    localparam int BCP_P_FONT = 4;
    localparam int BCP_P_COLOR = 8;
    localparam int BCP_P_SEARCH = 12;
    // x in the low half, y in the high half of coordinate words
    localparam int BCP_Y_POS = 16;
    // status register fields
    localparam int BCP_S_CLIPC = 0;
    localparam int BCP_S_CLIPR = 1;
    localparam int BCP_S_PICK = 2;
    localparam int BCP_S_OVF = 3;
    localparam int BCP_S_ARMED = 4;
    localparam int BCP_S_IDLE = 5;
    // values after reset
    localparam logic [8:0] BCP_CTRL_RST = 9'h000;
    localparam logic [15:0] BCP_PLANES_RST = 16'h000F;
    localparam logic [11:0] BCP_COORD_RST = 12'h000;
    localparam logic [11:0] BCP_BSIZE_RST = 12'h001;
    // write sequencer, gray along idle-check-brush-dest-write-next
    typedef enum logic [2:0] {
        BCP_ST_IDLE = 3'h0,
        BCP_ST_CHK = 3'h1,
        BCP_ST_BRD = 3'h3,
        BCP_ST_DRD = 3'h2,
        BCP_ST_WR = 3'h6,
        BCP_ST_NXT = 3'h7
    } bcp_state_t;
    // origin of a generated pixel
    typedef enum logic [1:0] {
        BCP_K_DRAW = 2'h0,
        BCP_K_COPY = 2'h1,
        BCP_K_BLKIN = 2'h2
    } bcp_kind_t;
    typedef struct packed {
        logic [BCP_CW-1:0] x;
        logic [BCP_CW-1:0] y;
    } bcp_xy_t;
    typedef struct packed {
        bcp_kind_t kind;
        bcp_xy_t xy;
        logic [BCP_NP-1:0] data;
    } bcp_pt_t;
    typedef struct packed {
        logic req;
        logic we;
        bcp_xy_t xy;
        logic [BCP_NP-1:0] wdata;
        logic [BCP_NP-1:0] wmask;
    } bcp_mreq_t;
endpackage : bcp_pkg

// ---- rtl/bcp_write_stage.sv ----
// module: pixel write stage with brush deposit, clipping and picking
// How it works
// - one active brush, enabled by software, base gives its upper-left corner
// - brush from all planes, or from the font plane replicated into active planes
// - replication only reaches planes of this device
// - with brush off the plane-source bit drives anti-aliasing instead
// - invert bit complements the brush; ignored with brush off
// - colour-qualify, for brush drawing and copies, stores only where destination equals the search colour
// - block size write stores halved width and height offsets, truncated
// - point with brush: offsets subtracted, brush corner at the result
// - line with brush: same offset shift applied to every interpolated pixel
// - arc and circle with brush: same offset shift for every curve pixel
// - with clipping on, writes outside the clip rectangle are dropped
// - rectangle edges count as inside, for clip and pick alike
// - block input ignores clipping; copies and draws do not
// - outside write raises clip condition until an inside write; request sticks
// - clipping drops writes only; overflow flag still set when clipped
// - picking drops all writes, flags writes that would land inside
// - pick flag re-arms only after an attempt outside the region
// - pixel-exact picking without brush; host aligns bounds otherwise
// - copy with match: pick is decided at check, before the match read
// - each written pixel combines with destination per raster-op field
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module bcp_write_stage #(
    parameter int CW = bcp_pkg::BCP_CW,
    parameter int NP = bcp_pkg::BCP_NP,
    parameter logic [11:0] MAX_X = bcp_pkg::BCP_MAX_X,
    parameter logic [11:0] MAX_Y = bcp_pkg::BCP_MAX_Y
) (
    input wire logic clk, // 10 MHz system clock
    input wire logic resetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped
    input wire logic pt_valid, // generated pixel offered
    output logic pt_ready, // stage can take a pixel
    input wire bcp_pkg::bcp_pt_t pt, // pixel address and data
    output bcp_pkg::bcp_mreq_t mem, // display memory request
    input wire logic mem_ack, // memory done, one cycle
    input wire logic [bcp_pkg::BCP_NP-1:0] mem_rdata, // read data with ack
    output logic aa_enable // anti-aliasing control out
);
    import bcp_pkg::*;

    localparam int TW = CW + 2;

    // refuse shapes the carriers cannot hold
    if (CW != BCP_CW || NP != BCP_NP || NP > 4 || NP < 1) begin : g_bad
        $error("bcp_write_stage: CW/NP must match the package, NP 1..4");
    end

    // reset release through two flops
    logic rst_meta_reg;
    logic rst_n;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // software visible state
    logic [8:0] ctrl_reg;
    logic [15:0] planes_reg;
    bcp_xy_t brush_reg, bsize_reg, offs_reg;
    bcp_xy_t clo_reg, chi_reg, plo_reg, phi_reg;
    logic clipc_reg, clipr_reg, pick_reg, ovf_reg, armed_reg;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;

    // apb decode; one wait state, write lands on the ready edge
    wire apb_acc = psel & penable;
    wire apb_wr = apb_acc & pwrite & pready_reg;
    wire w_ctrl = apb_wr & (paddr == BCP_A_CTRL);
    wire w_planes = apb_wr & (paddr == BCP_A_PLANES);
    wire w_brush = apb_wr & (paddr == BCP_A_BRUSH);
    wire w_bsize = apb_wr & (paddr == BCP_A_BSIZE);
    wire w_clo = apb_wr & (paddr == BCP_A_CLIP_LO);
    wire w_chi = apb_wr & (paddr == BCP_A_CLIP_HI);
    wire w_plo = apb_wr & (paddr == BCP_A_PICK_LO);
    wire w_phi = apb_wr & (paddr == BCP_A_PICK_HI);
    wire w_stat = apb_wr & (paddr == BCP_A_STATUS);
    wire addr_ok = (paddr[1:0] == 2'h0) & (paddr <= BCP_A_STATUS);
    bcp_xy_t wxy;
    assign wxy = '{x: pwdata[CW-1:0], y: pwdata[BCP_Y_POS+CW-1:BCP_Y_POS]};

    // control fields
    wire brush_en = ctrl_reg[BCP_C_BRUSH];
    wire clip_en = ctrl_reg[BCP_C_CLIP];
    wire pick_en = ctrl_reg[BCP_C_PICK];
    wire psrc = ctrl_reg[BCP_C_PSRC];
    wire inv_sel = ctrl_reg[BCP_C_INV];
    wire qual = ctrl_reg[BCP_C_QUAL];
    wire [2:0] rop = ctrl_reg[BCP_C_ROP+2:BCP_C_ROP];
    wire [NP-1:0] act = planes_reg[BCP_P_ACT+NP-1:BCP_P_ACT];
    wire [1:0] font = planes_reg[BCP_P_FONT+1:BCP_P_FONT];
    wire [NP-1:0] color = planes_reg[BCP_P_COLOR+NP-1:BCP_P_COLOR];
    wire [NP-1:0] search = planes_reg[BCP_P_SEARCH+NP-1:BCP_P_SEARCH];

    // sequencer state
    bcp_state_t st_reg, st_next;
    bcp_pt_t cur_reg, cur_next;
    logic [CW-1:0] bi_reg, bi_next, bj_reg, bj_next;
    logic ub_reg, ub_next;
    logic [NP-1:0] bpix_reg, bpix_next, dst_reg, dst_next;
    bcp_mreq_t mem_reg, mem_next;
    logic ptr_reg;

    // brush pixel target; shifting every generated pixel equals shifting
    // the end points or the centre before interpolation
    logic signed [TW-1:0] tx, ty;
    wire [CW-1:0] offx = ub_reg ? offs_reg.x : '0;
    wire [CW-1:0] offy = ub_reg ? offs_reg.y : '0;
    assign tx = $signed({2'b00, cur_reg.xy.x}) + $signed({2'b00, bi_reg}) - $signed({2'b00, offx});
    assign ty = $signed({2'b00, cur_reg.xy.y}) + $signed({2'b00, bj_reg}) - $signed({2'b00, offy});
    bcp_xy_t tgt;
    assign tgt = '{x: tx[CW-1:0], y: ty[CW-1:0]};
    wire ovf = tx[TW-1] | tx[TW-2] | ty[TW-1] | ty[TW-2] | (tgt.x > MAX_X) | (tgt.y > MAX_Y);

    // inclusive rectangle tests, per brush pixel
    wire in_clip = ~ovf & (tgt.x >= clo_reg.x) & (tgt.x <= chi_reg.x) & (tgt.y >= clo_reg.y) & (tgt.y <= chi_reg.y);
    wire in_pick = ~ovf & (tgt.x >= plo_reg.x) & (tgt.x <= phi_reg.x) & (tgt.y >= plo_reg.y) & (tgt.y <= phi_reg.y);
    wire chk = (st_reg == BCP_ST_CHK);
    wire no_clip = (cur_reg.kind == BCP_K_BLKIN);
    wire clip_out = clip_en & ~in_clip & ~no_clip;
    wire go = ~pick_en & ~ovf & ~clip_out;
    // matching only for brush drawing and copies
    wire match_on = qual & (ub_reg | (cur_reg.kind == BCP_K_COPY));

    // brush extent; a zero size still deposits one pixel
    wire [CW:0] bw = (bsize_reg.x == '0) ? (CW+1)'(1) : {1'b0, bsize_reg.x};
    wire [CW:0] bh = (bsize_reg.y == '0) ? (CW+1)'(1) : {1'b0, bsize_reg.y};
    wire x_last = ~ub_reg | (({1'b0, bi_reg} + (CW+1)'(1)) >= bw);
    wire y_last = ~ub_reg | (({1'b0, bj_reg} + (CW+1)'(1)) >= bh);

    // source planes: replication stays inside this device's planes
    wire fbit = (int'(font) < NP) ? bpix_reg[font] : 1'b0;
    wire [NP-1:0] brep = psrc ? {NP{fbit}} : bpix_reg;
    wire [NP-1:0] bsrc = inv_sel ? ~brep : brep;
    wire [NP-1:0] plain = (cur_reg.kind == BCP_K_DRAW) ? {NP{1'b1}} : cur_reg.data;
    wire [NP-1:0] src = ub_reg ? bsrc : plain;

    // raster operation per plane on source, destination and colour
    logic [NP-1:0] wd;
    for (genvar p = 0; p < NP; p++) begin : g_rop
        always_comb
        begin
            case (rop)
                3'h0: wd[p] = src[p];
                3'h1: wd[p] = dst_reg[p] | src[p];
                3'h2: wd[p] = dst_reg[p] & src[p];
                3'h3: wd[p] = dst_reg[p] ^ src[p];
                3'h4: wd[p] = dst_reg[p] & ~src[p];
                3'h5: wd[p] = color[p] ? (dst_reg[p] | src[p]) : (dst_reg[p] & ~src[p]);
                3'h6: wd[p] = color[p] ? (dst_reg[p] | src[p]) : dst_reg[p];
                default: wd[p] = color[p] ? (dst_reg[p] ^ src[p]) : dst_reg[p];
            endcase
        end
    end

    // sequencer: check, fetch brush pixel, read destination, write
    always_comb
    begin
        st_next = st_reg;
        cur_next = cur_reg;
        bi_next = bi_reg;
        bj_next = bj_reg;
        ub_next = ub_reg;
        bpix_next = bpix_reg;
        dst_next = dst_reg;
        mem_next = mem_reg;
        if (mem_ack)
            mem_next.req = 1'b0;
        case (st_reg)
            BCP_ST_IDLE:
                if (pt_valid & ptr_reg) begin
                    cur_next = pt;
                    bi_next = '0;
                    bj_next = '0;
                    // brush applies to every drawn pixel
                    ub_next = brush_en & (pt.kind == BCP_K_DRAW);
                    st_next = BCP_ST_CHK;
                end
            BCP_ST_CHK:
                if (!go)
                    st_next = BCP_ST_NXT;
                else if (ub_reg) begin
                    // brush read relative to its upper-left corner
                    mem_next = '{req: 1'b1, we: 1'b0, xy: '{x: brush_reg.x + bi_reg, y: brush_reg.y + bj_reg},
                                 wdata: '0, wmask: '0};
                    st_next = BCP_ST_BRD;
                end else begin
                    mem_next = '{req: 1'b1, we: 1'b0, xy: tgt, wdata: '0, wmask: '0};
                    st_next = BCP_ST_DRD;
                end
            BCP_ST_BRD:
                if (mem_ack) begin
                    bpix_next = mem_rdata;
                    mem_next = '{req: 1'b1, we: 1'b0, xy: tgt, wdata: '0, wmask: '0};
                    st_next = BCP_ST_DRD;
                end
            BCP_ST_DRD:
                if (mem_ack) begin
                    dst_next = mem_rdata;
                    if (match_on && (mem_rdata != search))
                        st_next = BCP_ST_NXT;
                    else
                        st_next = BCP_ST_WR;
                end
            BCP_ST_WR:
                // write issued one cycle after dest so the raster op sees it
                if (!mem_reg.req) begin
                    mem_next = '{req: 1'b1, we: 1'b1, xy: tgt, wdata: wd, wmask: act};
                    st_next = BCP_ST_NXT;
                end
            BCP_ST_NXT:
                if (mem_reg.req & ~mem_ack)
                    st_next = BCP_ST_NXT;
                else if (x_last & y_last)
                    st_next = BCP_ST_IDLE;
                else begin
                    bi_next = x_last ? '0 : bi_reg + 1'b1;
                    bj_next = x_last ? bj_reg + 1'b1 : bj_reg;
                    st_next = BCP_ST_CHK;
                end
            default:
                st_next = BCP_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) begin
            st_reg <= BCP_ST_IDLE;
            cur_reg <= '0;
            bi_reg <= '0;
            bj_reg <= '0;
            ub_reg <= 1'b0;
            bpix_reg <= '0;
            dst_reg <= '0;
            mem_reg <= '0;
            ptr_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cur_reg <= cur_next;
            bi_reg <= bi_next;
            bj_reg <= bj_next;
            ub_reg <= ub_next;
            bpix_reg <= bpix_next;
            dst_reg <= dst_next;
            mem_reg <= mem_next;
            ptr_reg <= (st_next == BCP_ST_IDLE);
        end
    end

    // flag events at check, before any match read; set wins over a clear
    wire clip_set = chk & clip_out;
    wire clip_clr = chk & go & in_clip;
    wire pick_set = chk & pick_en & in_pick & armed_reg;
    wire pick_rearm = chk & pick_en & ~in_pick;
    wire ovf_set = chk & ovf;
    wire c_clipr = w_stat & pwdata[BCP_S_CLIPR];
    wire c_pick = w_stat & pwdata[BCP_S_PICK];
    wire c_ovf = w_stat & pwdata[BCP_S_OVF];

    // flags and software registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) begin
            clipc_reg <= 1'b0;
            clipr_reg <= 1'b0;
            pick_reg <= 1'b0;
            ovf_reg <= 1'b0;
            armed_reg <= 1'b1;
            ctrl_reg <= BCP_CTRL_RST;
            planes_reg <= BCP_PLANES_RST;
            brush_reg <= '{BCP_COORD_RST, BCP_COORD_RST};
            bsize_reg <= '{BCP_BSIZE_RST, BCP_BSIZE_RST};
            offs_reg <= '{BCP_COORD_RST, BCP_COORD_RST};
            clo_reg <= '{BCP_COORD_RST, BCP_COORD_RST};
            chi_reg <= '{BCP_COORD_RST, BCP_COORD_RST};
            plo_reg <= '{BCP_COORD_RST, BCP_COORD_RST};
            phi_reg <= '{BCP_COORD_RST, BCP_COORD_RST};
        end else begin
            // condition follows writes, request holds until cleared
            clipc_reg <= clip_set | (clipc_reg & ~clip_clr);
            clipr_reg <= clip_set | (clipr_reg & ~c_clipr);
            // pick flag disarms itself until an outside attempt
            pick_reg <= pick_set | (pick_reg & ~c_pick);
            armed_reg <= pick_rearm | (armed_reg & ~pick_set);
            // overflow noted even on clipped pixels
            ovf_reg <= ovf_set | (ovf_reg & ~c_ovf);
            if (w_ctrl)
                ctrl_reg <= pwdata[8:0];
            if (w_planes)
                planes_reg <= pwdata[15:0];
            if (w_brush)
                brush_reg <= wxy;
            // offsets are half the block, truncated
            if (w_bsize) begin
                bsize_reg <= wxy;
                offs_reg <= '{x: wxy.x >> 1, y: wxy.y >> 1};
            end
            if (w_clo)
                clo_reg <= wxy;
            if (w_chi)
                chi_reg <= wxy;
            if (w_plo)
                plo_reg <= wxy;
            if (w_phi)
                phi_reg <= wxy;
        end
    end

    // read selection; reserved bits read zero
    function automatic logic [31:0] xy32(input bcp_xy_t v);
        xy32 = 32'(v.x) | (32'(v.y) << BCP_Y_POS);
    endfunction : xy32
    wire [5:0] stat = {st_reg == BCP_ST_IDLE, armed_reg, ovf_reg, pick_reg, clipr_reg, clipc_reg};
    wire [31:0] rd_mux =
        (paddr == BCP_A_CTRL) ? 32'(ctrl_reg) :
        (paddr == BCP_A_PLANES) ? 32'(planes_reg) :
        (paddr == BCP_A_BRUSH) ? xy32(brush_reg) :
        (paddr == BCP_A_BSIZE) ? xy32(bsize_reg) :
        (paddr == BCP_A_OFFS) ? xy32(offs_reg) :
        (paddr == BCP_A_CLIP_LO) ? xy32(clo_reg) :
        (paddr == BCP_A_CLIP_HI) ? xy32(chi_reg) :
        (paddr == BCP_A_PICK_LO) ? xy32(plo_reg) :
        (paddr == BCP_A_PICK_HI) ? xy32(phi_reg) :
        (paddr == BCP_A_STATUS) ? 32'(stat) : 32'h0000_0000;

    // apb answer registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= apb_acc & ~pready_reg;
            pslverr_reg <= apb_acc & ~pready_reg & ~addr_ok;
            if (apb_acc & ~pready_reg & ~pwrite)
                prdata_reg <= rd_mux;
        end
    end

    // anti-aliasing output registered from control
    logic aa_reg;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            aa_reg <= 1'b0;
        else
            // plane-source bit reused when the brush is off
            aa_reg <= psrc & ~brush_en;
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pt_ready = ptr_reg;
    assign mem = mem_reg;
    assign aa_enable = aa_reg;

    // checks on the write stage
    a_pick_no_write: assert property (chk && pick_en |=> st_reg == BCP_ST_NXT && !mem_reg.req)
        else $error("write attempted while picking");
    a_clip_suppress: assert property (chk && clip_out |=> st_reg == BCP_ST_NXT)
        else $error("write outside clip window");
    a_clip_raise: assert property (chk && clip_out |=> clipc_reg && clipr_reg)
        else $error("clip condition not raised");
    a_clip_inside: assert property (chk && go && in_clip |=> !clipc_reg)
        else $error("clip condition not cleared by inside write");
    a_blkin_noclip: assert property (chk && no_clip && !pick_en && !ovf |=> st_reg != BCP_ST_NXT)
        else $error("block input was clipped");
    a_pick_detect: assert property (chk && pick_en && in_pick && armed_reg |=> pick_reg && !armed_reg)
        else $error("pick not detected");
    a_pick_rearm: assert property (!armed_reg && !pick_rearm |=> !armed_reg)
        else $error("pick re-armed without outside attempt");
    a_ovf_flag: assert property (chk && ovf |=> ovf_reg)
        else $error("overflow not flagged");
    a_offset_half: assert property (w_bsize |=> offs_reg.x == $past(pwdata[CW-1:1]))
        else $error("brush offset not half the block");
    a_match_skip: assert property (st_reg == BCP_ST_DRD && mem_ack && match_on && mem_rdata != search
                                   |=> st_reg == BCP_ST_NXT ##1 !mem_reg.we)
        else $error("unmatched pixel written");
    a_write_mask: assert property (mem_reg.req && mem_reg.we |-> mem_reg.wmask == act)
        else $error("write mask differs from activity bits");
    a_aa_route: assert property (brush_en |=> !aa_enable)
        else $error("anti-aliasing on with brush");

    c_brush_write: cover property (ub_reg && mem_reg.req && mem_reg.we);
    c_pick_hit: cover property (pick_set);
    c_clip_hit: cover property (clip_set);
    c_match_skip: cover property (st_reg == BCP_ST_DRD && mem_ack && match_on && mem_rdata != search);
endmodule : bcp_write_stage

// ---- bench/bcp_mem_model.sv ----
// display memory model answering the write stage
`timescale 1ns/1ps
module bcp_mem_model
    import bcp_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic resetn, // active low
    input wire bcp_pkg::bcp_mreq_t mem, // request from stage
    output logic mem_ack, // one-cycle completion
    output logic [bcp_pkg::BCP_NP-1:0] mem_rdata // read data with ack
);
    logic [3:0] ram [0:255];
    logic [1:0] cnt_reg;
    logic slow_reg;
    wire [7:0] idx = {mem.xy.y[3:0], mem.xy.x[3:0]};
    initial for (int i = 0; i < 256; i++) ram[i] = 4'h0;
    // answers alternate prompt and slow; stale read data is inverted so it never looks valid
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mem_ack <= 1'b0;
            cnt_reg <= 2'h0;
            slow_reg <= 1'b0;
            mem_rdata <= 4'h5;
        end
        else if (mem_ack || !mem.req)
        begin
            mem_ack <= 1'b0;
            cnt_reg <= 2'h0;
            mem_rdata <= ~mem_rdata;
        end
        else if (cnt_reg == {slow_reg, 1'b0})
        begin
            mem_ack <= 1'b1;
            slow_reg <= ~slow_reg;
            mem_rdata <= ram[idx];
            if (mem.we) ram[idx] <= (ram[idx] & ~mem.wmask) | (mem.wdata & mem.wmask);
        end
        else
            cnt_reg <= cnt_reg + 2'h1;
    end
endmodule : bcp_mem_model

// ---- bench/tb_top.sv ----
// testbench: register access, clipping, picking and brush deposit
`timescale 1ns/1ps
module tb_top;
    import bcp_pkg::*;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pt_valid = 0, pready, pslverr, pt_ready;
    logic mem_ack, aa_enable;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] mem_rdata;
    bcp_pt_t pt = '0;
    bcp_mreq_t mem;
    bcp_kind_t pk = BCP_K_DRAW;
    logic [3:0] pd = 4'h0;
    int n_mismatch = 0, n_compared = 0;
    always #50 clk = ~clk;
    bcp_write_stage #(.MAX_X(12'h00F), .MAX_Y(12'h00F)) DUT (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pt_valid(pt_valid), .pt_ready(pt_ready), .pt(pt), .mem(mem), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .aa_enable(aa_enable));
    bcp_mem_model u_mem (.clk(clk), .resetn(resetn), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // offer one point of kind pk with data pd and wait until every pixel of it is done
    task pnt(input logic [11:0] x, input logic [11:0] y);
        @(posedge clk);
        pt_valid <= 1'b1;
        pt <= {pk, x, y, pd};
        do @(posedge clk); while (pt_ready !== 1'b1);
        pt_valid <= 1'b0;
        @(posedge clk);
        do @(posedge clk); while (pt_ready !== 1'b1);
    endtask : pnt
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test;
    end
    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        apb(0, BCP_A_PLANES, 0);
        chk(rd, 32'h0000_000F);
        apb(0, 8'h28, 0);
        chk({31'h0, pslverr}, 32'h1);
        apb(1, BCP_A_BSIZE, 32'h0004_0005);
        apb(0, BCP_A_OFFS, 0);
        chk(rd, 32'h0002_0002);
        apb(1, BCP_A_CTRL, 32'h8);
        repeat (3) @(posedge clk);
        chk({31'h0, aa_enable}, 32'h1);
        apb(1, BCP_A_CLIP_LO, 32'h0002_0002); // clip window 2..5 in x and y; point (6,3) falls outside on x
        apb(1, BCP_A_CLIP_HI, 32'h0005_0005);
        apb(1, BCP_A_CTRL, 32'h2);
        pnt(5, 5);
        chk(u_mem.ram[8'h55], 4'hF);
        pnt(6, 3);
        chk(u_mem.ram[8'h36], 4'h0);
        apb(0, BCP_A_STATUS, 0);
        chk(rd & 32'hB, 32'h3);
        pnt(20, 3);
        apb(0, BCP_A_STATUS, 0);
        chk(rd & 32'hB, 32'hB);
        pnt(2, 2);
        apb(0, BCP_A_STATUS, 0);
        chk(rd & 32'hB, 32'hA);
        apb(1, BCP_A_STATUS, 32'hE);
        apb(0, BCP_A_STATUS, 0);
        chk(rd & 32'hB, 32'h0);
        apb(1, BCP_A_PICK_LO, 32'h0008_0008); // pixel bounds, no brush
        apb(1, BCP_A_PICK_HI, 32'h0009_0009);
        apb(1, BCP_A_CTRL, 32'h4);
        pnt(9, 8);
        chk(u_mem.ram[8'h89], 4'h0);
        apb(0, BCP_A_STATUS, 0);
        chk(rd & 32'h24, 32'h24);
        apb(1, BCP_A_STATUS, 32'h4);
        pnt(8, 8);
        apb(0, BCP_A_STATUS, 0);
        chk(rd & 32'h24, 32'h20);
        pnt(1, 1);
        pnt(8, 8);
        apb(0, BCP_A_STATUS, 0);
        chk(rd & 32'h4, 32'h4);
        u_mem.ram[8'hCC] = 4'hA;
        u_mem.ram[8'hCD] = 4'h5;
        u_mem.ram[8'hDC] = 4'h3;
        u_mem.ram[8'hDD] = 4'hC;
        apb(1, BCP_A_BSIZE, 32'h0002_0002);
        apb(1, BCP_A_BRUSH, 32'h000C_000C);
        apb(1, BCP_A_CTRL, 32'h11); // brush on, so no anti-aliasing
        pnt(4, 4);
        chk({u_mem.ram[8'h33], u_mem.ram[8'h34], u_mem.ram[8'h43], u_mem.ram[8'h44]}, 16'h5AC3);
        // match against search colour 5: only the pixel whose destination is 5 takes the brush
        apb(1, BCP_A_PLANES, 32'h500F);
        apb(1, BCP_A_CTRL, 32'h21);
        pnt(4, 4);
        chk({u_mem.ram[8'h33], u_mem.ram[8'h34], u_mem.ram[8'h43], u_mem.ram[8'h44]}, 16'hAAC3);
        // font plane 1 replicated, only planes 0 and 1 active
        apb(1, BCP_A_PLANES, 32'h0013);
        apb(1, BCP_A_CTRL, 32'h9);
        pnt(4, 4);
        chk({u_mem.ram[8'h33], u_mem.ram[8'h34], u_mem.ram[8'h43], u_mem.ram[8'h44]}, 16'hB8F0);
        chk({31'h0, aa_enable}, 32'h0);
        // graphical xor with colour 5; block input ignores the clip window, a copy does not
        apb(1, BCP_A_PLANES, 32'h050F);
        apb(1, BCP_A_CTRL, 32'h1C2);
        pk = BCP_K_BLKIN;
        pd = 4'h6;
        pnt(7, 7);
        pk = BCP_K_COPY;
        pnt(7, 6);
        chk({u_mem.ram[8'h77], u_mem.ram[8'h67]}, 8'h40);
        finish_test;
    end
endmodule : tb_top
